// ==== pkg/urr_pkg.sv ====
// Shared constants and types of the receive recovery block
package urr_pkg;
    // --------------------------------------------------------------------
    // Sampling
    // --------------------------------------------------------------------
    localparam logic [4:0] SPB_NORMAL = 5'h10; // Samples per bit, normal speed
    localparam logic [4:0] SPB_DOUBLE = 5'h08; // Samples per bit, double speed
    localparam logic [4:0] VOTE_FIRST_N = 5'h08;
    localparam logic [4:0] VOTE_LAST_N = 5'h0a;
    localparam logic [4:0] VOTE_FIRST_D = 5'h04;
    localparam logic [4:0] VOTE_LAST_D = 5'h06;
    localparam logic [4:0] SAMPLE_ONE = 5'h01;
    localparam logic [1:0] VOTE_MAJ = 2'h2;    // Votes needed for a majority
    // --------------------------------------------------------------------
    // Frame format
    // --------------------------------------------------------------------
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ODD = 2'h3;
    localparam logic [3:0] SPI_LAST_BIT = 4'h7;
    // --------------------------------------------------------------------
    // Buffer entry and received-data-high layout
    // --------------------------------------------------------------------
    localparam int BUF_DEPTH = 2;
    localparam int ENTRY_W = 12;
    localparam int ENT_OVF = 11;
    localparam int ENT_FRAME_ERROR_FLAG = 10;
    localparam int ENT_PERR = 9;
    localparam int HI_RXC = 7;
    localparam int HI_OVF = 6;
    localparam int HI_FRAME_ERROR_FLAG = 2;
    localparam int HI_PERR = 1;
    localparam int HI_DATA8 = 0;
    typedef logic [ENTRY_W-1:0] urr_entry_t;
    typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_HOLD} urr_state_e;
endpackage : urr_pkg

// ==== pkg/urr_buf_if.sv ====
// Link between the receiver core and its receive buffer
`timescale 1ns/1ps
`default_nettype none
interface urr_buf_if;
    import urr_pkg::*;
    logic push;
    urr_entry_t push_entry;
    logic pop;
    logic flush;
    logic [1:0] count;
    urr_entry_t head;
    modport core (output push, output push_entry, output pop, output flush,
                  input count, input head);
    modport buffer (input push, input push_entry, input pop, input flush,
                    output count, output head);
endinterface : urr_buf_if
`default_nettype wire

// ==== verilog/urr_rx_buffer.sv ====
// Two-entry receive buffer holding each frame with its error flags
`timescale 1ns/1ps
`default_nettype none
module urr_rx_buffer
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Core side
    urr_buf_if.buffer b
);
    import urr_pkg::*;

    typedef struct packed {
        logic [1:0] count;
        urr_entry_t [BUF_DEPTH-1:0] ent;
    } urr_buf_s;

    urr_buf_s r;
    urr_buf_s next_r;

    // Pop shifts the queue, push lands behind it; push after pop wins
    always_comb
    begin
        logic [1:0] left;
        left = r.count;
        next_r = r;
        if (b.flush)
        begin
            next_r = '0;
        end
        else
        begin
            if (b.pop && r.count != 2'h0)
            begin
                left = r.count - 2'h1;
                for (int i = 0; i < BUF_DEPTH - 1; i++)
                begin
                    next_r.ent[i] = r.ent[i+1];
                end
                next_r.ent[BUF_DEPTH-1] = '0;
            end
            if (b.push)
            begin
                if (left < 2'(BUF_DEPTH))
                begin
                    next_r.ent[left[0]] = b.push_entry;
                    left = left + 2'h1;
                end
                else
                begin
                    next_r.ent[BUF_DEPTH-1][ENT_OVF] = 1'b1; // Frame lost
                end
            end
            next_r.count = left;
        end
    end

    // State register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            r <= '0;
        else
            r <= next_r;
    end

    assign b.count = r.count;
    assign b.head = r.ent[0];

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    chk_pop_advance: assert property ((b.pop && !b.flush && !b.push && r.count == 2'h2)
        |=> r.count == 2'h1) else $error("pop did not advance buffer");
    chk_flush_empty: assert property (b.flush |=> r.count == 2'h0)
        else $error("flush left entries");
endmodule : urr_rx_buffer
`default_nettype wire

// ==== verilog/urr_rx_core.sv ====
// Receiver clock and data recovery with master SPI transfer engine
`timescale 1ns/1ps
`default_nettype none
module urr_rx_core
(
    // Clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // Configuration
    input wire logic RX_ENABLE,
    input wire logic TX_ENABLE,
    input wire logic DOUBLE_SPEED_SELECT,
    input wire logic SPI_MODE,
    input wire logic LSB_FIRST,
    input wire logic [3:0] DATA_BITS,
    input wire logic [1:0] PARITY_MODE,
    input wire logic [15:0] BAUD_DIV,
    // Software access
    input wire logic READ_LOW,
    input wire logic DATA_WRITE,
    input wire logic [7:0] DATA_IN,
    // Status and received data
    output logic RECEIVE_COMPLETE_FLAG,
    output logic [7:0] RECEIVED_DATA_HIGH,
    output logic [7:0] RECEIVED_DATA_LOW,
    output logic TX_BUFFER_EMPTY,
    // Pins
    input wire logic RXD_PIN,
    output logic TXD_PIN,
    output logic TRANSFER_CLOCK_PIN
);
    import urr_pkg::*;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic [15:0] div;
        logic tick;
        urr_state_e state;
        logic [4:0] cnt;
        logic [1:0] votes;
        logic [3:0] bitidx;
        logic [8:0] data;
        logic pbit;
        logic spi_busy;
        logic [3:0] spi_bit;
        logic [7:0] tx_buf;
        logic tx_full;
        logic [7:0] tx_sh;
        logic [7:0] rx_sh;
        logic push;
        urr_entry_t push_entry;
        logic rxc;
        logic [7:0] hi;
        logic [7:0] lo;
        logic sck;
        logic mosi;
        logic txe;
    } urr_core_s;

    urr_core_s r;
    urr_core_s next_r;
    urr_buf_if b ();

    // --------------------------------------------------------------------
    // Sampling decode
    // --------------------------------------------------------------------
    logic [4:0] spb;
    logic [4:0] vfirst;
    logic [4:0] vlast;
    logic [3:0] nbits;
    logic vote_now;
    logic in_vote;
    logic [1:0] votes_now;

    // Rate and vote window per speed, majority including current sample
    always_comb
    begin
        spb = DOUBLE_SPEED_SELECT ? SPB_DOUBLE : SPB_NORMAL;
        vfirst = DOUBLE_SPEED_SELECT ? VOTE_FIRST_D : VOTE_FIRST_N;
        vlast = DOUBLE_SPEED_SELECT ? VOTE_LAST_D : VOTE_LAST_N;
        nbits = DATA_BITS + {3'h0, PARITY_MODE != PAR_NONE};
        in_vote = r.cnt >= vfirst && r.cnt <= vlast;
        votes_now = r.votes + {1'b0, r.sync2 & in_vote};
        vote_now = votes_now >= VOTE_MAJ;
    end

    // --------------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------------
    always_comb
    begin
        logic [7:0] sh;
        sh = '0;
        next_r = r;
        next_r.push = 1'b0;
        // Two-stage input synchroniser and sample tick divider
        next_r.sync1 = RXD_PIN;
        next_r.sync2 = r.sync1;
        next_r.tick = 1'b0;
        next_r.div = r.div + 16'h1;
        if (r.div >= BAUD_DIV)
        begin
            next_r.div = '0;
            next_r.tick = 1'b1;
        end
        // Asynchronous frame recovery
        if (r.tick && !SPI_MODE)
        begin
            next_r.prev = r.sync2;
            if (in_vote)
                next_r.votes = votes_now;
            next_r.cnt = r.cnt + 5'h1;
            case (r.state)
                S_IDLE:
                begin
                    if (r.prev && !r.sync2)
                    begin
                        next_r.state = S_START;
                        next_r.cnt = SAMPLE_ONE + 5'h1;
                        next_r.votes = '0;
                    end
                end
                S_START:
                begin
                    if (r.cnt == vlast)
                    begin
                        // Majority low accepts the start bit
                        next_r.state = vote_now ? S_IDLE : S_DATA;
                        next_r.bitidx = '0;
                        next_r.data = '0;
                    end
                end
                S_DATA:
                begin
                    if (r.cnt == vlast)
                    begin
                        if (r.bitidx < DATA_BITS)
                            next_r.data[r.bitidx] = vote_now;
                        else if (r.bitidx < nbits)
                            next_r.pbit = vote_now;
                        else
                        begin
                            // First stop bit closes the frame
                            next_r.push = RX_ENABLE;
                            next_r.push_entry = '0;
                            next_r.push_entry[8:0] = r.data;
                            next_r.push_entry[ENT_FRAME_ERROR_FLAG] = !vote_now;
                            next_r.push_entry[ENT_PERR] = (PARITY_MODE != PAR_NONE)
                                && ((^r.data ^ r.pbit) != (PARITY_MODE == PAR_ODD));
                            next_r.state = DOUBLE_SPEED_SELECT ? S_HOLD : S_IDLE;
                        end
                        // Advance after the vote so the tail of the start bit never counts
                        next_r.bitidx = r.bitidx + 4'h1;
                    end
                    if (r.cnt == spb)
                    begin
                        next_r.cnt = SAMPLE_ONE;
                        next_r.votes = '0;
                    end
                end
                S_HOLD:
                    next_r.state = S_IDLE;
                default:
                    next_r.state = S_IDLE;
            endcase
        end
        // Master SPI: buffered write feeds the shifter
        if (DATA_WRITE && !r.tx_full && SPI_MODE)
        begin
            next_r.tx_buf = DATA_IN;
            next_r.tx_full = 1'b1;
        end
        if (SPI_MODE && !r.spi_busy && r.tx_full && TX_ENABLE)
        begin
            next_r.spi_busy = 1'b1;
            next_r.tx_full = 1'b0; // A write refused while full is never replayed
            next_r.tx_sh = r.tx_buf;
            next_r.spi_bit = '0;
            next_r.mosi = LSB_FIRST ? r.tx_buf[0] : r.tx_buf[7];
        end
        else if (r.spi_busy && r.tick)
        begin
            next_r.sck = !r.sck;
            // A slave bit needs three clocks through the synchroniser: BAUD_DIV of 2 or more
            if (!r.sck)
                next_r.rx_sh = LSB_FIRST ? {r.sync2, r.rx_sh[7:1]} : {r.rx_sh[6:0], r.sync2};
            else if (r.spi_bit == SPI_LAST_BIT)
            begin
                next_r.spi_busy = 1'b0;
                next_r.push = RX_ENABLE;
                next_r.push_entry = {4'h0, r.rx_sh};
            end
            else
            begin
                sh = LSB_FIRST ? {1'b0, r.tx_sh[7:1]} : {r.tx_sh[6:0], 1'b0};
                next_r.tx_sh = sh;
                next_r.mosi = LSB_FIRST ? sh[0] : sh[7];
                next_r.spi_bit = r.spi_bit + 4'h1;
            end
        end
        if (!SPI_MODE)
        begin
            next_r.spi_busy = 1'b0;
            next_r.sck = 1'b0;
        end
        // Receiver disable drops the frame in flight
        if (!RX_ENABLE || SPI_MODE)
        begin
            next_r.state = S_IDLE;
            next_r.prev = 1'b0;
        end
        // Registered view of buffer head
        next_r.rxc = b.count != 2'h0;
        next_r.lo = b.head[7:0];
        next_r.hi = '0;
        next_r.hi[HI_RXC] = b.count != 2'h0;
        next_r.hi[HI_OVF] = b.head[ENT_OVF];
        next_r.hi[HI_FRAME_ERROR_FLAG] = b.head[ENT_FRAME_ERROR_FLAG];
        next_r.hi[HI_PERR] = b.head[ENT_PERR];
        next_r.hi[HI_DATA8] = b.head[8];
        next_r.txe = !next_r.tx_full;
    end

    // State register
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            r <= '0;
        else
            r <= next_r;
    end

    // --------------------------------------------------------------------
    // Buffer and outputs
    // --------------------------------------------------------------------
    assign b.push = r.push;
    assign b.push_entry = r.push_entry;
    assign b.pop = READ_LOW;
    assign b.flush = !RX_ENABLE;

    urr_rx_buffer u_buf (
        .clk(CLK),
        .arst_n(ARST_N),
        .b(b)
    );

    assign RECEIVE_COMPLETE_FLAG = r.rxc;
    assign RECEIVED_DATA_HIGH = r.hi;
    assign RECEIVED_DATA_LOW = r.lo;
    assign TX_BUFFER_EMPTY = r.txe;
    assign TXD_PIN = r.mosi;
    assign TRANSFER_CLOCK_PIN = r.sck;

    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    chk_disable_flush: assert property (!RX_ENABLE |=> r.state == S_IDLE ##2
        !RECEIVE_COMPLETE_FLAG) else $error("disable did not flush");
    chk_bit_wrap: assert property ((r.tick && r.state == S_DATA && r.cnt == spb && !SPI_MODE
        && RX_ENABLE) |=> r.cnt == 5'h1) else $error("bit counter wrap wrong");
    chk_double_span: assert property ((DOUBLE_SPEED_SELECT && r.state == S_DATA)
        |-> r.cnt <= 5'h8) else $error("double speed exceeds eight samples");
    chk_start_edge: assert property ((r.tick && r.state == S_IDLE && r.prev && !r.sync2
        && !SPI_MODE && RX_ENABLE) |=> r.state == S_START && r.cnt == 5'h2)
        else $error("start detection not begun");
    chk_start_reject: assert property ((r.tick && r.state == S_START && r.cnt == vlast
        && votes_now >= 2'h2 && !SPI_MODE && RX_ENABLE) |=> r.state == S_IDLE)
        else $error("noise start accepted");
    chk_stop_frame_error_flag: assert property ((r.tick && r.state == S_DATA && r.cnt == vlast
        && r.bitidx == nbits && !SPI_MODE && RX_ENABLE) |=> r.push
        && r.push_entry[ENT_FRAME_ERROR_FLAG] == !$past(vote_now)) else $error("frame error wrong");
    chk_spi_errs: assert property ((r.push && SPI_MODE) |-> r.push_entry[ENT_OVF:ENT_PERR]
        == 3'h0) else $error("spi error flag set");
    chk_spi_start: assert property ((SPI_MODE && !r.spi_busy && r.tx_full && TX_ENABLE)
        |=> r.spi_busy && !r.sck) else $error("spi transfer not started");
endmodule : urr_rx_core
`default_nettype wire

// ==== tb/urr_far_end.sv ====
// Far-end model: remote asynchronous transmitter and master-mode SPI slave
`timescale 1ns/1ps
`default_nettype none
module urr_far_end
(
    // Clock
    input wire logic clk,
    // Pins
    input wire logic spi_on,
    input wire logic sck,
    input wire logic mosi,
    output logic rxd
);
    logic line = 1'b1;
    logic [7:0] slave_tx = 8'h00;
    logic [7:0] slave_rx = 8'h00;
    // ----------------------------------------------------------------
    // SPI slave
    // ----------------------------------------------------------------
    // Slave bit on the line in SPI mode, idle-high frame line otherwise
    assign rxd = spi_on ? slave_tx[7] : line;
    // Capture on rising clock, shift on falling; refill with a changing bit
    always @(posedge sck) slave_rx <= {slave_rx[6:0], mosi};
    always @(negedge sck) slave_tx <= {slave_tx[6:0], ~slave_tx[0]};
    // ----------------------------------------------------------------
    // Asynchronous transmitter
    // ----------------------------------------------------------------
    // Hold a level for n clocks, entered at a falling edge
    task automatic hold_line(input logic lvl, input int n);
        line = lvl;
        repeat (n) @(negedge clk);
    endtask : hold_line
    // One frame, LSB first, at the nominal bit period in clocks
    task automatic send(input logic [8:0] d, input int nb, input int bitc,
                        input logic stop, input int stopc);
        int i;
        hold_line(1'b0, bitc);
        for (i = 0; i < nb; i++)
        begin
            hold_line(d[i], bitc);
        end
        hold_line(stop, stopc);
        line = 1'b1;
    endtask : send
endmodule : urr_far_end
`default_nettype wire

// ==== tb/test_usart_async_receiver_recovery.sv ====
// Self-checking bench of the receive recovery block
`timescale 1ns/1ps
`default_nettype none
module test_usart_async_receiver_recovery;
    import urr_pkg::*;
    localparam int DIV = 1;
    localparam int BITN = 16 * (DIV + 1);
    localparam int BITD = 8 * (DIV + 1);
    logic CLK, ARST_N, RX_ENABLE, TX_ENABLE, DOUBLE_SPEED_SELECT, SPI_MODE;
    logic LSB_FIRST, READ_LOW, DATA_WRITE, RXD_PIN, TXD_PIN, TRANSFER_CLOCK_PIN;
    logic RECEIVE_COMPLETE_FLAG, TX_BUFFER_EMPTY;
    logic [3:0] DATA_BITS;
    logic [1:0] PARITY_MODE;
    logic [15:0] BAUD_DIV;
    logic [7:0] DATA_IN, RECEIVED_DATA_HIGH, RECEIVED_DATA_LOW;
    int n_fail = 0;
    int samples_checked = 0;
    // ----------------------------------------------------------------
    // Design and far end
    // ----------------------------------------------------------------
    urr_rx_core dut (.CLK(CLK), .ARST_N(ARST_N), .RX_ENABLE(RX_ENABLE),
        .TX_ENABLE(TX_ENABLE), .DOUBLE_SPEED_SELECT(DOUBLE_SPEED_SELECT),
        .SPI_MODE(SPI_MODE), .LSB_FIRST(LSB_FIRST), .DATA_BITS(DATA_BITS),
        .PARITY_MODE(PARITY_MODE), .BAUD_DIV(BAUD_DIV), .READ_LOW(READ_LOW),
        .DATA_WRITE(DATA_WRITE), .DATA_IN(DATA_IN),
        .RECEIVE_COMPLETE_FLAG(RECEIVE_COMPLETE_FLAG),
        .RECEIVED_DATA_HIGH(RECEIVED_DATA_HIGH), .RECEIVED_DATA_LOW(RECEIVED_DATA_LOW),
        .TX_BUFFER_EMPTY(TX_BUFFER_EMPTY), .RXD_PIN(RXD_PIN), .TXD_PIN(TXD_PIN),
        .TRANSFER_CLOCK_PIN(TRANSFER_CLOCK_PIN));
    urr_far_end far (.clk(CLK), .spi_on(SPI_MODE), .sck(TRANSFER_CLOCK_PIN),
        .mosi(TXD_PIN), .rxd(RXD_PIN));
    // Clock at 20 MHz
    initial
    begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude
    task automatic expect8(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
            n_fail++;
        end
    endtask : expect8
    // Bounded wait for the receive-complete flag
    task automatic wait_rxc;
        int i;
        for (i = 0; i < 2000 && RECEIVE_COMPLETE_FLAG !== 1'b1; i++) @(negedge CLK);
        if (RECEIVE_COMPLETE_FLAG !== 1'b1)
        begin
            $display("[FAIL] %0t receive complete never rose", $time);
            n_fail++;
            conclude();
        end
    endtask : wait_rxc
    // High byte first, then the low byte whose read advances the buffer
    task automatic read_entry(input logic [7:0] lo, input logic [7:0] hi);
        expect8(RECEIVED_DATA_HIGH, hi, "high byte");
        expect8(RECEIVED_DATA_LOW, lo, "low byte");
        READ_LOW = 1'b1;
        @(negedge CLK);
        READ_LOW = 1'b0;
        repeat (3) @(negedge CLK);
    endtask : read_entry
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_normal;
        far.send(9'h0a5, 8, BITN, 1'b1, BITN);
        wait_rxc();
        read_entry(8'ha5, 8'h80);
        expect8({7'h00, RECEIVE_COMPLETE_FLAG}, 8'h00, "flag after read");
        $display("normal speed frame done");
    endtask : t_normal
    task automatic t_b2b_frame_error_flag;
        far.send(9'h03c, 8, BITN, 1'b1, 12 * (DIV + 1));
        far.send(9'h0c3, 8, BITN, 1'b0, BITN);
        far.hold_line(1'b1, 2 * BITN);
        wait_rxc();
        read_entry(8'h3c, 8'h80);
        read_entry(8'hc3, 8'h84);
        $display("back-to-back and frame error done");
    endtask : t_b2b_frame_error_flag
    task automatic t_double;
        DOUBLE_SPEED_SELECT = 1'b1;
        DATA_BITS = 4'h9;
        far.send(9'h1a6, 9, BITD, 1'b1, 2 * BITD);
        far.hold_line(1'b1, BITD);
        wait_rxc();
        read_entry(8'ha6, 8'h81);
        DOUBLE_SPEED_SELECT = 1'b0;
        DATA_BITS = 4'h8;
        $display("double speed frame done");
    endtask : t_double
    task automatic t_noise;
        far.hold_line(1'b0, 8 * (DIV + 1));
        // Long enough for a wrongly accepted spike to complete a whole frame
        far.hold_line(1'b1, 12 * BITN);
        expect8({7'h00, RECEIVE_COMPLETE_FLAG}, 8'h00, "spike taken as frame");
        far.send(9'h081, 8, BITN, 1'b1, BITN);
        wait_rxc();
        read_entry(8'h81, 8'h80);
        // Odd parity: a good parity bit, then a bad one
        PARITY_MODE = PAR_ODD;
        far.send(9'h181, 9, BITN, 1'b1, BITN);
        far.send(9'h081, 9, BITN, 1'b1, BITN);
        wait_rxc();
        read_entry(8'h81, 8'h80);
        read_entry(8'h81, 8'h82);
        PARITY_MODE = PAR_NONE;
        $display("noise spike done");
    endtask : t_noise
    task automatic t_disable;
        far.send(9'h011, 8, BITN, 1'b1, BITN);
        fork
            far.send(9'h0ff, 8, BITN, 1'b1, BITN);
        join_none
        repeat (4 * BITN) @(negedge CLK);
        RX_ENABLE = 1'b0;
        repeat (3) @(negedge CLK);
        expect8({7'h00, RECEIVE_COMPLETE_FLAG}, 8'h00, "flag after disable");
        // Re-enable while the cut frame is still on the line
        repeat (BITN) @(negedge CLK);
        RX_ENABLE = 1'b1;
        repeat (7 * BITN) @(negedge CLK);
        far.send(9'h022, 8, BITN, 1'b1, BITN);
        wait_rxc();
        read_entry(8'h22, 8'h80);
        expect8({7'h00, RECEIVE_COMPLETE_FLAG}, 8'h00, "stale entry left");
        $display("receiver disable done");
    endtask : t_disable
    task automatic spi_write(input logic [7:0] d);
        int i;
        for (i = 0; i < 100 && TX_BUFFER_EMPTY !== 1'b1; i++) @(negedge CLK);
        if (TX_BUFFER_EMPTY !== 1'b1)
        begin
            $display("[FAIL] %0t transmit buffer never emptied", $time);
            n_fail++;
            conclude();
        end
        DATA_IN = d;
        DATA_WRITE = 1'b1;
        @(negedge CLK);
        DATA_WRITE = 1'b0;
    endtask : spi_write
    task automatic t_spi;
        // Half period of four clocks lets each slave bit cross the input synchroniser
        BAUD_DIV = 16'h0003;
        SPI_MODE = 1'b1;
        TX_ENABLE = 1'b1;
        far.slave_tx = 8'hc3;
        spi_write(8'h3c);
        wait_rxc();
        read_entry(8'hc3, 8'h80);
        expect8(far.slave_rx, 8'h3c, "slave received");
        expect8({7'h00, TRANSFER_CLOCK_PIN}, 8'h00, "clock idle level");
        // Least significant bit first: both bytes arrive reversed at the other end
        LSB_FIRST = 1'b1;
        far.slave_tx = 8'h12;
        spi_write(8'h35);
        wait_rxc();
        expect8(RECEIVED_DATA_HIGH, 8'h80, "lsb first high byte");
        expect8(RECEIVED_DATA_LOW, 8'h48, "lsb first low byte");
        expect8(far.slave_rx, 8'hac, "lsb first slave received");
        RX_ENABLE = 1'b0;
        repeat (3) @(negedge CLK);
        expect8({7'h00, RECEIVE_COMPLETE_FLAG}, 8'h00, "spi disable flush");
        RX_ENABLE = 1'b1;
        SPI_MODE = 1'b0;
        LSB_FIRST = 1'b0;
        BAUD_DIV = 16'h0001;
        $display("master spi done");
    endtask : t_spi
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        ARST_N = 1'b0;
        RX_ENABLE = 1'b1;
        TX_ENABLE = 1'b0;
        DOUBLE_SPEED_SELECT = 1'b0;
        SPI_MODE = 1'b0;
        LSB_FIRST = 1'b0;
        DATA_BITS = 4'h8;
        PARITY_MODE = PAR_NONE;
        BAUD_DIV = 16'h0001;
        READ_LOW = 1'b0;
        DATA_WRITE = 1'b0;
        DATA_IN = 8'h00;
        repeat (3) @(negedge CLK);
        ARST_N = 1'b1;
        repeat (3) @(negedge CLK);
        t_normal();
        t_b2b_frame_error_flag();
        t_double();
        t_noise();
        t_disable();
        t_spi();
        conclude();
    end
endmodule : test_usart_async_receiver_recovery
`default_nettype wire
